// ===== rtl/ppl_port_core.sv
// Port group 8/9 pull-up select, direction and output latch access.
// Assumes the CPU presents one access per cycle on the memory bus;
// pins are external and pass through a synchroniser first.
//
// Operation
// - Group 8 pull-up select, two bits
// - Pull-up only when selected and input
// - Same gating for alternate pin functions
// - Reset clears group 8 pull-up select
// - Group 9 pull-up select, eight bits
// - Reset clears group 9 pull-up select
// - Pull-up selects take bit and byte writes
// - Output pin drives its written latch
// - Latch holds value until next write
// - Input pin write updates latch only
// - Output pin read returns latch
// - Input pin read returns pin level
// - Output pin RMW uses and stores latch
// - Input pin RMW may spoil latch only
// - Bit access runs as byte access
// - Direction 0 drives, 1 is input
`timescale 1ns/100ps
`default_nettype none
`include "ppl_map.svh"
module ppl_port_core
    import ppl_pkg::*;
(
    input  wire logic                 ref_clk_in,
    input  wire logic                 rst_in,
    input  wire logic [15:0]          cpu_addr_in,
    input  wire logic                 cpu_wr_in,
    input  wire logic                 cpu_rd_in,
    input  wire logic                 cpu_bit_in,
    input  wire logic [2:0]           cpu_bit_sel_in,
    input  wire logic [7:0]           cpu_wdata_in,
    output logic      [7:0]           cpu_rdata_out,
    output logic                      cpu_rvalid_out,
    input  wire logic [`PPL_G8_W-1:0] group8_pin_in,
    output logic      [`PPL_G8_W-1:0] group8_pin_out,
    output logic      [`PPL_G8_W-1:0] group8_pin_oe_out,
    output logic      [`PPL_G8_W-1:0] group8_pullup_out,
    input  wire logic [`PPL_G9_W-1:0] group9_pin_in,
    output logic      [`PPL_G9_W-1:0] group9_pin_out,
    output logic      [`PPL_G9_W-1:0] group9_pin_oe_out,
    output logic      [`PPL_G9_W-1:0] group9_pullup_out
);
    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [`PPL_G8_W-1:0] pullup_select_group8_q, pullup_select_group8_d;
    logic [`PPL_G9_W-1:0] pullup_select_group9_q, pullup_select_group9_d;
    logic [`PPL_G8_W-1:0] dir8_q, dir8_d;
    logic [`PPL_G9_W-1:0] dir9_q, dir9_d;
    logic [`PPL_G8_W-1:0] lat8_q, lat8_d;
    logic [`PPL_G9_W-1:0] lat9_q, lat9_d;
    ppl_byte_t            rdata_q, rdata_d;
    logic                 rvalid_q, rvalid_d;

    // Synchronised pin levels
    logic [`PPL_G8_W-1:0] lvl8;
    logic [`PPL_G9_W-1:0] lvl9;

    // Access decode and byte views
    ppl_sel_e             sel;
    ppl_byte_t            view8_lat, view9_lat;
    ppl_byte_t            rd_view;
    ppl_byte_t            wr_val;

    // ----------------------------------------------------------------
    // Pin input synchronisers
    // ----------------------------------------------------------------
    ppl_pin_sync #(.W(`PPL_G8_W)) u_sync8 (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .pin_in     (group8_pin_in),
        .level_out  (lvl8)
    );
    ppl_pin_sync #(.W(`PPL_G9_W)) u_sync9 (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .pin_in     (group9_pin_in),
        .level_out  (lvl9)
    );

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    // Unmapped addresses select nothing and read back zero
    always_comb begin
        case (cpu_addr_in)
            `PPL_ADDR_LAT8: sel = PPL_SEL_LAT8;
            `PPL_ADDR_LAT9: sel = PPL_SEL_LAT9;
            `PPL_ADDR_DIR8: sel = PPL_SEL_DIR8;
            `PPL_ADDR_DIR9: sel = PPL_SEL_DIR9;
            `PPL_ADDR_PU8:  sel = PPL_SEL_PU8;
            `PPL_ADDR_PU9:  sel = PPL_SEL_PU9;
            default:        sel = PPL_SEL_NONE;
        endcase
    end

    // ----------------------------------------------------------------
    // Read view of each register
    // ----------------------------------------------------------------
    // Port read mixes latch (output pins) with pin level (input pins)
    always_comb begin
        view8_lat = {`PPL_G8_PAD_ZERO,
                     (dir8_q & lvl8) | (~dir8_q & lat8_q)};
        view9_lat = (dir9_q & lvl9) | (~dir9_q & lat9_q);
    end

    // Byte presented for reads and as the base of a bit access
    always_comb begin
        case (sel)
            PPL_SEL_LAT8: rd_view = view8_lat;
            PPL_SEL_LAT9: rd_view = view9_lat;
            PPL_SEL_DIR8: rd_view = {`PPL_G8_PAD_ONE, dir8_q};
            PPL_SEL_DIR9: rd_view = dir9_q;
            PPL_SEL_PU8:  rd_view = {`PPL_G8_PAD_ZERO,
                                     pullup_select_group8_q};
            PPL_SEL_PU9:  rd_view = pullup_select_group9_q;
            default:      rd_view = `PPL_RDATA_RST;
        endcase
    end

    // ----------------------------------------------------------------
    // Write value
    // ----------------------------------------------------------------
    // A bit access reads the whole byte, patches one bit and writes the
    // whole byte back. On a port this copies pin levels into the
    // latches of other input pins, which software must treat as
    // undefined; output pins keep their latch contents.
    always_comb begin
        wr_val = cpu_wdata_in;
        if (cpu_bit_in) begin
            wr_val                 = rd_view;
            wr_val[cpu_bit_sel_in] = cpu_wdata_in[0];
        end
    end

    // ----------------------------------------------------------------
    // Register next state
    // ----------------------------------------------------------------
    // Only the addressed register changes; all others hold
    always_comb begin
        pullup_select_group8_d = pullup_select_group8_q;
        pullup_select_group9_d = pullup_select_group9_q;
        dir8_d                 = dir8_q;
        dir9_d                 = dir9_q;
        lat8_d                 = lat8_q;
        lat9_d                 = lat9_q;
        if (cpu_wr_in) begin
            case (sel)
                PPL_SEL_LAT8: lat8_d = wr_val[`PPL_G8_W-1:0];
                PPL_SEL_LAT9: lat9_d = wr_val;
                PPL_SEL_DIR8: dir8_d = wr_val[`PPL_G8_W-1:0];
                PPL_SEL_DIR9: dir9_d = wr_val;
                PPL_SEL_PU8: begin
                    // Upper six bits have no storage
                    pullup_select_group8_d = wr_val[`PPL_G8_W-1:0];
                end
                PPL_SEL_PU9: begin
                    pullup_select_group9_d = wr_val;
                end
                default: begin
                end
            endcase
        end
    end

    // Register file flops; reset leaves every pin an input, no pull-up
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            pullup_select_group8_q <= `PPL_G8_W'(`PPL_PU_RST);
            pullup_select_group9_q <= `PPL_PU_RST;
            dir8_q                 <= `PPL_G8_W'(`PPL_DIR_RST);
            dir9_q                 <= `PPL_DIR_RST;
            lat8_q                 <= `PPL_G8_W'(`PPL_LAT_RST);
            lat9_q                 <= `PPL_LAT_RST;
        end else begin
            pullup_select_group8_q <= pullup_select_group8_d;
            pullup_select_group9_q <= pullup_select_group9_d;
            dir8_q                 <= dir8_d;
            dir9_q                 <= dir9_d;
            lat8_q                 <= lat8_d;
            lat9_q                 <= lat9_d;
        end
    end

    // ----------------------------------------------------------------
    // Read data path
    // ----------------------------------------------------------------
    // A write in the same cycle wins; the read is dropped
    always_comb begin
        rvalid_d = cpu_rd_in && !cpu_wr_in;
        rdata_d  = rdata_q;
        if (rvalid_d) begin
            rdata_d = rd_view;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            rdata_q  <= `PPL_RDATA_RST;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign cpu_rdata_out  = rdata_q;
    assign cpu_rvalid_out = rvalid_q;

    // ----------------------------------------------------------------
    // Pad control per group
    // ----------------------------------------------------------------
    ppl_port_if #(.W(`PPL_G8_W)) g8_if ();
    ppl_port_if #(.W(`PPL_G9_W)) g9_if ();

    // Core side of the carriers
    assign g8_if.dir    = dir8_q;
    assign g8_if.latch  = lat8_q;
    assign g8_if.pu_sel = pullup_select_group8_q;
    assign g9_if.dir    = dir9_q;
    assign g9_if.latch  = lat9_q;
    assign g9_if.pu_sel = pullup_select_group9_q;

    ppl_pad_ctl #(.W(`PPL_G8_W)) u_pad8 (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .port       (g8_if.pad)
    );
    ppl_pad_ctl #(.W(`PPL_G9_W)) u_pad9 (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .port       (g9_if.pad)
    );

    // Pin outputs come straight from pad flops
    assign group8_pin_out    = g8_if.out;
    assign group8_pin_oe_out = g8_if.oe;
    assign group8_pullup_out = g8_if.pu_en;
    assign group9_pin_out    = g9_if.out;
    assign group9_pin_oe_out = g9_if.oe;
    assign group9_pullup_out = g9_if.pu_en;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    // Steps of a byte and a bit write to the group 9 pull-up select, and of a bit write to the group 9 latch
    sequence s_pu9_byte_wr;
        cpu_wr_in && !cpu_bit_in && (sel == PPL_SEL_PU9);
    endsequence
    sequence s_pu9_bit_wr;
        cpu_wr_in && cpu_bit_in && (sel == PPL_SEL_PU9);
    endsequence
    sequence s_lat9_bit_wr;
        cpu_wr_in && cpu_bit_in && (sel == PPL_SEL_LAT9);
    endsequence

    AST_PU8_AFTER_RESET: assert property (
        $past(rst_in) |-> (pullup_select_group8_q == '0))
        else $error("group 8 pull-up select not cleared by reset");

    AST_PU9_AFTER_RESET: assert property (
        $past(rst_in) |-> (pullup_select_group9_q == '0))
        else $error("group 9 pull-up select not cleared by reset");

    AST_PU9_BYTE_WRITE: assert property (
        s_pu9_byte_wr |=> pullup_select_group9_q == $past(cpu_wdata_in))
        else $error("byte write to group 9 pull-up select lost");

    AST_PU9_BIT_WRITE: assert property (
        s_pu9_bit_wr |=>
            (pullup_select_group9_q[$past(cpu_bit_sel_in)]
                 == $past(cpu_wdata_in[0]))
            && ((pullup_select_group9_q ^ $past(pullup_select_group9_q))
                 & ~(`PPL_BIT_ONE << $past(cpu_bit_sel_in))) == '0)
        else $error("bit write to group 9 pull-up select wrong");

    AST_PU8_UPPER_ZERO: assert property (
        (cpu_rd_in && !cpu_wr_in && sel == PPL_SEL_PU8) |=>
            cpu_rvalid_out
            && (cpu_rdata_out[7:`PPL_G8_W] == `PPL_G8_PAD_ZERO))
        else $error("group 8 pull-up upper bits not zero");

    AST_LAT9_HOLDS: assert property (
        !(cpu_wr_in && sel == PPL_SEL_LAT9) |=> $stable(lat9_q))
        else $error("group 9 latch changed without a write");

    AST_LAT9_READ_VIEW: assert property (
        (cpu_rd_in && !cpu_wr_in && sel == PPL_SEL_LAT9) |=>
            cpu_rdata_out == (($past(dir9_q) & $past(lvl9))
                              | (~$past(dir9_q) & $past(lat9_q))))
        else $error("port 9 read returned wrong source");

    AST_LAT9_BIT_RMW: assert property (
        s_lat9_bit_wr |=>
            ((lat9_q ^ $past(lat9_q)) & ~$past(dir9_q)
             & ~(`PPL_BIT_ONE << $past(cpu_bit_sel_in))) == '0)
        else $error("bit access disturbed an output pin latch");

    AST_LAT9_TO_PIN: assert property (
        (cpu_wr_in && !cpu_bit_in && sel == PPL_SEL_LAT9) |=> ##1
            group9_pin_out == $past(cpu_wdata_in, 2))
        else $error("written latch value not driven out");

    AST_INPUT_PIN_UNDRIVEN: assert property (
        ##1 ((group9_pin_oe_out & $past(dir9_q)) == '0))
        else $error("input pin has its driver on");

    // Every pin comes out of reset as an input with its driver off
    AST_DIR_AFTER_RESET: assert property (
        $past(rst_in) |-> (dir9_q == `PPL_DIR_RST) && (&dir8_q))
        else $error("direction registers not set to input by reset");

    // Group 8 pull-up select keeps the low two bits of a byte write
    AST_PU8_BYTE_WRITE: assert property (
        (cpu_wr_in && !cpu_bit_in && sel == PPL_SEL_PU8) |=>
            pullup_select_group8_q == $past(cpu_wdata_in[`PPL_G8_W-1:0]))
        else $error("byte write to group 8 pull-up select lost");

    // No group 8 pull-up on a driven pin, whatever the pin is used for
    AST_PU8_INPUT_ONLY: assert property (
        (group8_pullup_out & group8_pin_oe_out) == '0)
        else $error("group 8 pull-up on a driven pin");

    // Every taken read is answered by one valid pulse, nothing else is
    AST_RVALID_ON_READ: assert property (
        (cpu_rd_in && !cpu_wr_in) |=> cpu_rvalid_out)
        else $error("read not answered in the next cycle");

    AST_RVALID_ONLY_READ: assert property (
        !(cpu_rd_in && !cpu_wr_in) |=> !cpu_rvalid_out)
        else $error("read valid without a read");

    // A byte write lands in the group 9 latch in either direction
    AST_LAT9_BYTE_WRITE: assert property (
        (cpu_wr_in && !cpu_bit_in && sel == PPL_SEL_LAT9) |=>
            lat9_q == $past(cpu_wdata_in))
        else $error("byte write to group 9 latch lost");

    // Group 9 pull-up enable is the select gated by input direction
    AST_PU9_GATED: assert property (
        ##1 group9_pullup_out
            == ($past(pullup_select_group9_q) & $past(dir9_q)))
        else $error("group 9 pull-up not gated by direction");
endmodule : ppl_port_core
`default_nettype wire

// ===== shared/ppl_map.svh
// Address map, reset values and widths of the port pull-up block.
// Assumes a 16-bit CPU data address space with byte-wide registers.
`ifndef PPL_MAP_SVH
`define PPL_MAP_SVH
// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define PPL_ADDR_LAT8    16'hFF08
`define PPL_ADDR_LAT9    16'hFF09
`define PPL_ADDR_DIR8    16'hFF28
`define PPL_ADDR_DIR9    16'hFF29
`define PPL_ADDR_PU8     16'hFF38
`define PPL_ADDR_PU9     16'hFF39
// ----------------------------------------------------------------
// Reset values, widths and masks
// ----------------------------------------------------------------
`define PPL_PU_RST       8'h00
`define PPL_DIR_RST      8'hFF
`define PPL_LAT_RST      8'h00
`define PPL_RDATA_RST    8'h00
`define PPL_G8_W         2
`define PPL_G9_W         8
`define PPL_G8_PAD       6
`define PPL_G8_PAD_ZERO  6'h00
`define PPL_G8_PAD_ONE   6'h3F
`define PPL_BIT_ONE      8'h01
`endif

// ===== shared/ppl_pkg.sv
// Types shared by the port pull-up and latch access block.
// Assumes ppl_map.svh is on the include path.
`default_nettype none
`include "ppl_map.svh"
package ppl_pkg;
    // Register selected by the current CPU address
    typedef enum logic [2:0] {
        PPL_SEL_NONE,
        PPL_SEL_LAT8,
        PPL_SEL_LAT9,
        PPL_SEL_DIR8,
        PPL_SEL_DIR9,
        PPL_SEL_PU8,
        PPL_SEL_PU9
    } ppl_sel_e;
    typedef logic [7:0] ppl_byte_t;
endpackage : ppl_pkg
`default_nettype wire

// ===== shared/ppl_port_if.sv
// Carrier between the register core and one pin group's pad control.
// Assumes one clock domain; all fields are levels.
`timescale 1ns/100ps
`default_nettype none
interface ppl_port_if #(parameter int W = 8);
    logic [W-1:0] dir;     // 1 = input, 0 = output
    logic [W-1:0] latch;   // output latch contents
    logic [W-1:0] pu_sel;  // pull-up select bits
    logic [W-1:0] out;     // registered pin drive value
    logic [W-1:0] oe;      // registered output enable
    logic [W-1:0] pu_en;   // registered pull-up enable
    modport core (output dir, latch, pu_sel, input out, oe, pu_en);
    modport pad  (input dir, latch, pu_sel, output out, oe, pu_en);
endinterface : ppl_port_if
`default_nettype wire

// ===== rtl/ppl_pin_sync.sv
// Three-stage pin input synchroniser with agreement filter.
// Assumes raw pins are asynchronous to ref_clk_in.
`timescale 1ns/100ps
`default_nettype none
module ppl_pin_sync #(parameter int W = 8) (
    input  wire logic         ref_clk_in,
    input  wire logic         rst_in,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] level_out
);
    logic [W-1:0] s1_q, s2_q, s3_q, lvl_q;
    logic [W-1:0] s1_d, s2_d, s3_d, lvl_d;
    // Level only moves once stages two and three agree
    always_comb begin
        s1_d = pin_in;
        s2_d = s1_q;
        s3_d = s2_q;
        for (int i = 0; i < W; i++) begin
            lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
        end
    end
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            lvl_q <= '0;
        end else begin
            s1_q  <= s1_d;
            s2_q  <= s2_d;
            s3_q  <= s3_d;
            lvl_q <= lvl_d;
        end
    end
    assign level_out = lvl_q;
endmodule : ppl_pin_sync
`default_nettype wire

// ===== rtl/ppl_pad_ctl.sv
// Pad control for one pin group: drive, enable and pull-up gating.
// Assumes dir, latch and pu_sel come from flops on the same clock.
`timescale 1ns/100ps
`default_nettype none
module ppl_pad_ctl #(parameter int W = 8) (
    input  wire logic ref_clk_in,
    input  wire logic rst_in,
    ppl_port_if.pad   port
);
    logic [W-1:0] out_q, oe_q, pu_q, out_d, oe_d, pu_d;
    // Driver on for direction 0; pull-up only on input pins
    always_comb begin
        out_d = port.latch;
        oe_d  = ~port.dir;
        pu_d  = port.pu_sel & port.dir;
    end
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            out_q <= '0;
            oe_q  <= '0;
            pu_q  <= '0;
        end else begin
            out_q <= out_d;
            oe_q  <= oe_d;
            pu_q  <= pu_d;
        end
    end
    assign port.out   = out_q;
    assign port.oe    = oe_q;
    assign port.pu_en = pu_q;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    AST_NO_PULL_ON_DRIVER: assert property ((oe_q & pu_q) == '0)
        else $error("pull-up active on a driven pin");
    AST_PULL_FOLLOWS_SEL: assert property (
        ##1 pu_q == $past(port.pu_sel & port.dir))
        else $error("pull-up enable does not follow select and dir");
    AST_DRIVE_FOLLOWS: assert property (
        ##1 (oe_q == ~$past(port.dir)) && (out_q == $past(port.latch)))
        else $error("pin drive does not follow latch and dir");
endmodule : ppl_pad_ctl
`default_nettype wire

// ===== dv/ppl_pin_model.sv
// Behavioural model of the pads and board wiring of one pin group.
// Assumes drive, enable and pull-up come from the block under test.
`timescale 1ns/100ps
`default_nettype none
module ppl_pin_model #(parameter int W = 8) (
    input  wire logic         ref_clk_in,
    input  wire logic [W-1:0] drive_in,
    input  wire logic [W-1:0] oe_in,
    input  wire logic [W-1:0] pullup_in,
    input  wire logic [W-1:0] ext_val_in,
    input  wire logic [W-1:0] ext_drv_in,
    output logic      [W-1:0] level_out
);
    // ----------------------------------------------------------------
    // Floating lines
    // ----------------------------------------------------------------
    // Toggles each cycle so an undriven pin never reads as a steady value
    logic [W-1:0] flip_q = '0;
    always_ff @(posedge ref_clk_in) begin
        flip_q <= ~flip_q;
    end
    // ----------------------------------------------------------------
    // Wire level
    // ----------------------------------------------------------------
    // Device driver wins, then board driver, then pull-up
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (oe_in[i]) begin
                level_out[i] = drive_in[i];
            end else if (ext_drv_in[i]) begin
                level_out[i] = ext_val_in[i];
            end else if (pullup_in[i]) begin
                level_out[i] = 1'b1;
            end else begin
                level_out[i] = flip_q[i];
            end
        end
    end
endmodule : ppl_pin_model
`default_nettype wire

// ===== dv/testbench.sv
// Self-checking bench for the port pull-up and latch access block.
// Assumes the register map header and package are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "ppl_map.svh"
module testbench;
    logic       ref_clk = 1'b0;
    logic       rst     = 1'b1;
    logic [15:0] addr   = 16'h0000;
    logic       wr      = 1'b0;
    logic       rd_s    = 1'b0;
    logic       bit_s   = 1'b0;
    logic [2:0] bsel    = 3'h0;
    logic [7:0] wdata   = 8'h00;
    logic [7:0] rdata;
    logic       rvalid;
    logic [1:0] p8_in, p8_out, p8_oe, p8_pu;
    logic [7:0] p9_in, p9_out, p9_oe, p9_pu;
    logic [7:0] ext9_val = 8'h00;
    logic [7:0] ext9_drv = 8'hFF;
    logic [7:0] d;
    int         n_fail   = 0;
    int         checked  = 0;
    int         cycles   = 0;
    // ----------------------------------------------------------------
    // Clock, timeout and instances
    // ----------------------------------------------------------------
    initial begin
        forever #4 ref_clk = ~ref_clk;
    end
    // Whole run is well under two hundred cycles; a hang trips at 5000
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            finish_test();
        end
    end
    ppl_port_core i_dut (
        .ref_clk_in       (ref_clk), .rst_in            (rst),
        .cpu_addr_in      (addr),    .cpu_wr_in         (wr),
        .cpu_rd_in        (rd_s),    .cpu_bit_in        (bit_s),
        .cpu_bit_sel_in   (bsel),    .cpu_wdata_in      (wdata),
        .cpu_rdata_out    (rdata),   .cpu_rvalid_out    (rvalid),
        .group8_pin_in    (p8_in),   .group8_pin_out    (p8_out),
        .group8_pin_oe_out(p8_oe),   .group8_pullup_out (p8_pu),
        .group9_pin_in    (p9_in),   .group9_pin_out    (p9_out),
        .group9_pin_oe_out(p9_oe),   .group9_pullup_out (p9_pu));
    ppl_pin_model #(.W(2)) i_pins8 (
        .ref_clk_in(ref_clk), .drive_in(p8_out), .oe_in(p8_oe),
        .pullup_in(p8_pu), .ext_val_in(2'h0), .ext_drv_in(2'h0),
        .level_out(p8_in));
    ppl_pin_model #(.W(8)) i_pins9 (
        .ref_clk_in(ref_clk), .drive_in(p9_out), .oe_in(p9_oe),
        .pullup_in(p9_pu), .ext_val_in(ext9_val), .ext_drv_in(ext9_drv),
        .level_out(p9_in));
    // ----------------------------------------------------------------
    // Access tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: exp %h got %h", $time, exp, got);
        end
    endtask : chk
    // Byte or bit write; strobe held for exactly one taken edge
    task automatic wacc(input logic [15:0] a, input logic b,
                        input logic [2:0] s, input logic [7:0] v);
        @(posedge ref_clk);
        addr  <= a;
        wr    <= 1'b1;
        bit_s <= b;
        bsel  <= s;
        wdata <= v;
        @(posedge ref_clk);
        wr    <= 1'b0;
        bit_s <= 1'b0;
    endtask : wacc
    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        int n;
        @(posedge ref_clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge ref_clk);
        rd_s <= 1'b0;
        @(negedge ref_clk);
        for (n = 0; n < 4 && rvalid !== 1'b1; n++) @(negedge ref_clk);
        v = rdata;
        chk(8'h01, {7'h00, rvalid});
    endtask : rd
    task automatic rdc(input logic [15:0] a, input logic [7:0] m,
                       input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        chk(exp, v & m);
    endtask : rdc
    // Pin outputs follow a register two edges after the write
    task automatic settle();
        repeat (3) @(negedge ref_clk);
    endtask : settle
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        rdc(`PPL_ADDR_PU8, 8'hFF, 8'h00);
        rdc(`PPL_ADDR_PU9, 8'hFF, 8'h00);
        rdc(`PPL_ADDR_DIR9, 8'hFF, 8'hFF);
        chk(8'h00, {p8_oe, p8_pu, 4'h0});
        chk(8'h00, p9_oe | p9_pu);
        wacc(`PPL_ADDR_PU8, 1'b0, 3'h0, 8'hFF);
        rdc(`PPL_ADDR_PU8, 8'hFF, 8'h03);
        wacc(`PPL_ADDR_PU8, 1'b1, 3'h1, 8'h00);
        rdc(`PPL_ADDR_PU8, 8'hFF, 8'h01);
        wacc(`PPL_ADDR_PU9, 1'b0, 3'h0, 8'hA5);
        wacc(`PPL_ADDR_PU9, 1'b1, 3'h1, 8'h01);
        rdc(`PPL_ADDR_PU9, 8'hFF, 8'hA7);
        settle();
        chk(8'hA7, p9_pu);
        chk(8'h01, {6'h00, p8_pu});
        // Release the board lines; selected pull-ups hold those pins high
        @(posedge ref_clk);
        ext9_drv <= 8'h00;
        repeat (8) @(negedge ref_clk);
        rdc(`PPL_ADDR_LAT9, 8'hA7, 8'hA7);
        @(posedge ref_clk);
        ext9_val <= 8'h0A;
        ext9_drv <= 8'hFF;
        wacc(`PPL_ADDR_DIR9, 1'b0, 3'h0, 8'h0F);
        settle();
        chk(8'hF0, p9_oe);
        chk(8'h07, p9_pu);
        wacc(`PPL_ADDR_LAT9, 1'b0, 3'h0, 8'h3C);
        settle();
        chk(8'h30, p9_out & 8'hF0);
        repeat (6) @(negedge ref_clk);
        rdc(`PPL_ADDR_LAT9, 8'hFF, 8'h3A);
        // Arithmetic update done as read, add, write back
        rd(`PPL_ADDR_LAT9, d);
        wacc(`PPL_ADDR_LAT9, 1'b0, 3'h0, d + 8'h10);
        settle();
        chk(8'h40, p9_out & 8'hF0);
        wacc(`PPL_ADDR_LAT9, 1'b1, 3'h7, 8'h01);
        settle();
        chk(8'hC0, p9_out & 8'hF0);
        wacc(`PPL_ADDR_DIR9, 1'b0, 3'h0, 8'hFF);
        // Arithmetic update on input pins leaves the pins alone
        rd(`PPL_ADDR_LAT9, d);
        wacc(`PPL_ADDR_LAT9, 1'b0, 3'h0, d + 8'h01);
        settle();
        chk(8'h00, p9_oe);
        chk(8'h0A, p9_in);
        wacc(`PPL_ADDR_LAT9, 1'b0, 3'h0, 8'h55);
        settle();
        chk(8'h00, p9_oe);
        repeat (6) @(negedge ref_clk);
        rdc(`PPL_ADDR_LAT9, 8'hFF, 8'h0A);
        wacc(`PPL_ADDR_DIR9, 1'b0, 3'h0, 8'h0F);
        settle();
        chk(8'h50, p9_out & 8'hF0);
        wacc(`PPL_ADDR_DIR8, 1'b0, 3'h0, 8'h00);
        wacc(`PPL_ADDR_LAT8, 1'b0, 3'h0, 8'h02);
        settle();
        chk(8'h03, {6'h00, p8_oe});
        chk(8'h02, {6'h00, p8_out});
        chk(8'h00, {6'h00, p8_pu});
        rdc(`PPL_ADDR_LAT8, 8'hFF, 8'h02);
        rdc(16'hFF3A, 8'hFF, 8'h00);
        finish_test();
    end
endmodule : testbench
`default_nettype wire
